// *** flow_exec_cfg.svh ***
// Offsets, field positions, reset values and cycle counts of the flow-control executor
`ifndef FLOW_EXEC_CFG_SVH
`define FLOW_EXEC_CFG_SVH

`define OFS_STATUS_FLAGS 8'h00
`define OFS_EXT_PAGE     8'h04
`define OFS_PC           8'h08
`define OFS_EXEC_STATE   8'h0C

`define RST_STATUS_FLAGS 8'h00
`define RST_EXT_PAGE     8'h00
`define RST_PC           24'h000000

`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_H 5

`define CYC_ONE   3'h1
`define CYC_TWO   3'h2
`define CYC_THREE 3'h3
`define CYC_CALL  3'h4

`define STATE_BUSY_BIT 0
`define STATE_CYC_LSB  4

`endif

// *** flow_pkg.sv ***
// Types shared by the flow-control executor files
package flow_pkg;

  typedef enum logic [3:0] {
    indirect_call_op          = 4'h0,
    extended_indirect_call_op = 4'h1,
    compare_skip_equal_op     = 4'h2,
    compare_immediate_op      = 4'h3,
    reg_bit_clear_skip_op     = 4'h4,
    reg_bit_set_skip_op       = 4'h5,
    io_bit_clear_skip_op      = 4'h6,
    io_bit_set_skip_op        = 4'h7,
    flag_set_branch_op        = 4'h8,
    flag_clear_branch_op      = 4'h9,
    equal_branch_op           = 4'hA
  } op_type;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_run  = 2'b10
  } state_type;

endpackage

// *** cmp_alu.sv ***
// Subtract-and-discard flag generator for compare with immediate
`timescale 1ns/10ps
module cmp_alu (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  output logic            flag_c,
  output logic            flag_z,
  output logic            flag_n,
  output logic            flag_v,
  output logic            flag_h
);
  logic [7:0] diff;

  always_comb begin
    diff   = a - b;
    flag_z = (diff == 8'h00);
    flag_n = diff[7];
    flag_v = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);
    flag_c = (~a[7] & b[7]) | (b[7] & diff[7]) | (diff[7] & ~a[7]);
    flag_h = (~a[3] & b[3]) | (b[3] & diff[3]) | (diff[3] & ~a[3]);
  end
endmodule

// *** outcome_unit.sv ***
// Outcome of one flow instruction: target address and cycle count
`timescale 1ns/10ps
`include "flow_exec_cfg.svh"
module outcome_unit (
  input  wire flow_pkg::op_type op_code,
  input  wire logic [23:0]      pc,
  input  wire logic [7:0]       rd_value,
  input  wire logic [7:0]       rr_value,
  input  wire logic [7:0]       io_value,
  input  wire logic [2:0]       bit_sel,
  input  wire logic [2:0]       flag_sel,
  input  wire logic [6:0]       branch_offset,
  input  wire logic [15:0]      pointer_value,
  input  wire logic [7:0]       ext_page,
  input  wire logic [7:0]       status_flags,
  input  wire logic             next_two_word,
  output logic      [23:0]      target,
  output logic      [2:0]       cycles
);
  logic [23:0] seq;
  logic [23:0] ofs;
  logic        skip;

  always_comb begin
    seq    = pc + 24'h000001;
    ofs    = {{17{branch_offset[6]}}, branch_offset};
    skip   = 1'b0;
    target = seq;
    cycles = `CYC_ONE;
    case (op_code)
      flow_pkg::indirect_call_op: begin
        target = {8'h00, pointer_value};
        cycles = `CYC_CALL;
      end
      flow_pkg::extended_indirect_call_op: begin
        target = {ext_page, pointer_value};
        cycles = `CYC_CALL;
      end
      flow_pkg::compare_skip_equal_op: skip = (rd_value == rr_value);
      flow_pkg::reg_bit_clear_skip_op: skip = ~rr_value[bit_sel];
      flow_pkg::reg_bit_set_skip_op:   skip = rr_value[bit_sel];
      flow_pkg::io_bit_clear_skip_op:  skip = ~io_value[bit_sel];
      flow_pkg::io_bit_set_skip_op:    skip = io_value[bit_sel];
      flow_pkg::flag_set_branch_op: begin
        if (status_flags[flag_sel]) begin
          target = seq + ofs;
          cycles = `CYC_TWO;
        end
      end
      flow_pkg::flag_clear_branch_op: begin
        if (!status_flags[flag_sel]) begin
          target = seq + ofs;
          cycles = `CYC_TWO;
        end
      end
      flow_pkg::equal_branch_op: begin
        if (status_flags[`FLAG_Z]) begin
          target = seq + ofs;
          cycles = `CYC_TWO;
        end
      end
      default: begin
        target = seq;
        cycles = `CYC_ONE;
      end
    endcase
    // Skipped instruction length sets both the advance and the extra cycle
    if (skip) begin
      target = next_two_word ? pc + 24'h000003 : pc + 24'h000002;
      cycles = next_two_word ? `CYC_THREE : `CYC_TWO;
    end
  end
endmodule

// *** flow_exec.sv ***
// Program-flow instruction executor with APB register access
// How it works
// - Indirect call loads PC from pointer pair, flags kept, four cycles.
// - Extended indirect call target is page register above pointer, four cycles.
// - Compare-skip on equal registers advances PC by 2 or 3, flags kept.
// - Compare immediate subtracts, updates Z N V C H, one cycle.
// - Register bit clear skip advances PC when bit is zero.
// - Register bit set skip advances PC when bit is one.
// - I/O bit clear skip advances PC when bit is zero, flags kept.
// - I/O bit set skip advances PC when bit is one, 1 to 3 cycles.
// - Flag set branch jumps to PC plus k plus one, 1 or 2 cycles.
// - Flag clear branch jumps to PC plus k plus one, flags kept.
// - Equal branch jumps when zero flag is one, 1 or 2 cycles.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "flow_exec_cfg.svh"
module flow_exec (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             op_valid,
  input  wire flow_pkg::op_type op_code,
  input  wire logic [7:0]       rd_value,
  input  wire logic [7:0]       rr_value,
  input  wire logic [7:0]       imm_value,
  input  wire logic [2:0]       bit_sel,
  input  wire logic [2:0]       flag_sel,
  input  wire logic [6:0]       branch_offset,
  input  wire logic [7:0]       io_value,
  input  wire logic [15:0]      pointer_value,
  input  wire logic             next_two_word,
  output logic                  op_ready,
  output logic                  op_done,
  output logic      [23:0]      pc_value,
  output logic                  stack_push,
  output logic      [7:0]       stack_data
);

  function automatic logic is_call(input flow_pkg::op_type op);
    is_call = (op == flow_pkg::indirect_call_op) || (op == flow_pkg::extended_indirect_call_op);
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == `OFS_STATUS_FLAGS) || (addr == `OFS_EXT_PAGE) ||
                (addr == `OFS_PC) || (addr == `OFS_EXEC_STATE);
  endfunction

  flow_pkg::state_type state;
  flow_pkg::state_type next_state;
  logic [2:0]          remain;
  logic [2:0]          next_remain;
  logic [23:0]         pc;
  logic [23:0]         next_pc;
  logic [23:0]         pend_pc;
  logic [23:0]         next_pend_pc;
  logic [23:0]         ret_shift;
  logic [23:0]         next_ret_shift;
  logic                run_call;
  logic                next_run_call;
  logic                push;
  logic                next_push;
  logic [7:0]          push_data;
  logic [7:0]          next_push_data;
  logic                done;
  logic                next_done;
  logic [7:0]          status_flags;
  logic [7:0]          next_status_flags;
  logic [7:0]          ext_page;
  logic [7:0]          next_ext_page;
  logic [2:0]          last_cycles;
  logic [2:0]          next_last_cycles;
  logic [31:0]         rdata;
  logic [31:0]         next_rdata;

  logic                accept;
  logic                wr_en;
  logic [23:0]         ret_addr;
  logic [23:0]         target;
  logic [2:0]          cycles;
  logic                cmp_c;
  logic                cmp_z;
  logic                cmp_n;
  logic                cmp_v;
  logic                cmp_h;

  outcome_unit u_outcome (
    .op_code       (op_code),
    .pc            (pc),
    .rd_value      (rd_value),
    .rr_value      (rr_value),
    .io_value      (io_value),
    .bit_sel       (bit_sel),
    .flag_sel      (flag_sel),
    .branch_offset (branch_offset),
    .pointer_value (pointer_value),
    .ext_page      (ext_page),
    .status_flags  (status_flags),
    .next_two_word (next_two_word),
    .target        (target),
    .cycles        (cycles)
  );

  cmp_alu u_cmp (
    .a      (rd_value),
    .b      (imm_value),
    .flag_c (cmp_c),
    .flag_z (cmp_z),
    .flag_n (cmp_n),
    .flag_v (cmp_v),
    .flag_h (cmp_h)
  );

  assign op_ready   = (state == flow_pkg::st_idle);
  assign accept     = op_valid && op_ready;
  assign wr_en      = psel && penable && pwrite;
  assign ret_addr   = pc + 24'h000001;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !is_mapped(paddr);
  assign prdata     = rdata;
  assign op_done    = done;
  assign pc_value   = pc;
  assign stack_push = push;
  assign stack_data = push_data;

  // APB read data is captured in the setup cycle so the access phase needs no wait
  always_comb begin
    next_rdata = rdata;
    if (psel && !penable) begin
      case (paddr)
        `OFS_STATUS_FLAGS: next_rdata = {24'h000000, status_flags};
        `OFS_EXT_PAGE:     next_rdata = {24'h000000, ext_page};
        `OFS_PC:           next_rdata = {8'h00, pc};
        `OFS_EXEC_STATE:   next_rdata = {25'h0000000, last_cycles, 3'h0, (state == flow_pkg::st_run)};
        default:           next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= next_rdata;
    end
  end

  always_comb begin
    next_state        = state;
    next_remain       = remain;
    next_pc           = pc;
    next_pend_pc      = pend_pc;
    next_ret_shift    = ret_shift;
    next_run_call     = run_call;
    next_push         = 1'b0;
    next_push_data    = push_data;
    next_done         = 1'b0;
    next_status_flags = status_flags;
    next_ext_page     = ext_page;
    next_last_cycles  = last_cycles;
    // Software writes first; a compare in the same cycle overrides the flags
    if (wr_en) begin
      case (paddr)
        `OFS_STATUS_FLAGS: next_status_flags = pwdata[7:0];
        `OFS_EXT_PAGE:     next_ext_page = pwdata[7:0];
        `OFS_PC: begin
          if (op_ready && !accept) begin
            next_pc = pwdata[23:0];
          end
        end
        default: next_ext_page = ext_page;
      endcase
    end
    case (state)
      flow_pkg::st_idle: begin
        if (accept) begin
          next_last_cycles = cycles;
          next_run_call    = is_call(op_code);
          if (op_code == flow_pkg::compare_immediate_op) begin
            next_status_flags[`FLAG_C] = cmp_c;
            next_status_flags[`FLAG_Z] = cmp_z;
            next_status_flags[`FLAG_N] = cmp_n;
            next_status_flags[`FLAG_V] = cmp_v;
            next_status_flags[`FLAG_H] = cmp_h;
          end
          if (cycles == `CYC_ONE) begin
            next_pc   = target;
            next_done = 1'b1;
          end else begin
            next_state   = flow_pkg::st_run;
            next_remain  = cycles - `CYC_ONE;
            next_pend_pc = target;
            if (is_call(op_code)) begin
              next_push      = 1'b1;
              next_push_data = ret_addr[7:0];
              next_ret_shift = {8'h00, ret_addr[23:8]};
            end
          end
        end
      end
      flow_pkg::st_run: begin
        next_remain = remain - `CYC_ONE;
        if (remain == `CYC_ONE) begin
          // Control moves only after the last return byte has gone out
          next_pc    = pend_pc;
          next_done  = 1'b1;
          next_state = flow_pkg::st_idle;
        end else if (run_call) begin
          next_push      = 1'b1;
          next_push_data = ret_shift[7:0];
          next_ret_shift = {8'h00, ret_shift[23:8]};
        end
      end
      default: begin
        next_state = flow_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= flow_pkg::st_idle;
      remain       <= 3'h0;
      pc           <= `RST_PC;
      pend_pc      <= `RST_PC;
      ret_shift    <= 24'h000000;
      run_call     <= 1'b0;
      push         <= 1'b0;
      push_data    <= 8'h00;
      done         <= 1'b0;
      status_flags <= `RST_STATUS_FLAGS;
      ext_page     <= `RST_EXT_PAGE;
      last_cycles  <= 3'h0;
    end else begin
      state        <= next_state;
      remain       <= next_remain;
      pc           <= next_pc;
      pend_pc      <= next_pend_pc;
      ret_shift    <= next_ret_shift;
      run_call     <= next_run_call;
      push         <= next_push;
      push_data    <= next_push_data;
      done         <= next_done;
      status_flags <= next_status_flags;
      ext_page     <= next_ext_page;
      last_cycles  <= next_last_cycles;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence push_three_bytes;
    stack_push [*3] ##1 (!stack_push && op_done);
  endsequence

  sequence call_accepted;
    accept && is_call(op_code) && !wr_en;
  endsequence

  a_indirect_call_op_target: assert property (
    accept && op_code == flow_pkg::indirect_call_op |->
      ##4 (op_done && pc_value == {8'h00, $past(pointer_value, 4)}))
    else $error("indirect call target or timing wrong");

  a_extended_indirect_call_op_target: assert property (
    accept && op_code == flow_pkg::extended_indirect_call_op && !wr_en |->
      ##4 (op_done && pc_value == {$past(ext_page, 4), $past(pointer_value, 4)}))
    else $error("extended indirect call target or timing wrong");

  a_call_push_order: assert property (
    call_accepted |-> ##1 (stack_data == $past(pc_value[7:0]) + 8'h01 && pc_value == $past(pc_value)) ##0 push_three_bytes)
    else $error("return address not pushed before control transfer");

  a_call_flags_kept: assert property (
    call_accepted ##1 !wr_en [*3] |-> status_flags == $past(status_flags, 3))
    else $error("call changed status flags");

  a_compare_skip_equal_op_skip_short: assert property (
    accept && op_code == flow_pkg::compare_skip_equal_op && rd_value == rr_value && !next_two_word |->
      ##1 !op_done ##1 (op_done && pc_value == $past(pc_value, 2) + 24'h000002))
    else $error("compare skip over one word wrong");

  a_skip_long_word: assert property (
    accept && op_code == flow_pkg::io_bit_set_skip_op && io_value[bit_sel] && next_two_word |->
      ##3 (op_done && pc_value == $past(pc_value, 3) + 24'h000003))
    else $error("skip over two words wrong");

  a_cpi_flags: assert property (
    accept && op_code == flow_pkg::compare_immediate_op |=>
      op_done && op_ready && status_flags[`FLAG_Z] == ($past(rd_value) == $past(imm_value)) &&
      status_flags[`FLAG_C] == ($past(rd_value) < $past(imm_value)))
    else $error("compare immediate flags wrong");

  a_reg_bit_clear_skip_op_no_skip: assert property (
    accept && op_code == flow_pkg::reg_bit_clear_skip_op && rr_value[bit_sel] |=>
      op_done && pc_value == $past(pc_value) + 24'h000001)
    else $error("register bit clear skip taken wrongly");

  a_reg_bit_set_skip_op_skip: assert property (
    accept && op_code == flow_pkg::reg_bit_set_skip_op && rr_value[bit_sel] && !next_two_word |->
      ##2 (pc_value == $past(pc_value, 2) + 24'h000002))
    else $error("register bit set skip wrong");

  a_io_bit_clear_skip_op_skip: assert property (
    accept && op_code == flow_pkg::io_bit_clear_skip_op && !io_value[bit_sel] && !wr_en && !next_two_word |->
      ##1 $stable(status_flags) ##1 (op_done && pc_value == $past(pc_value, 2) + 24'h000002))
    else $error("I/O bit clear skip wrong");

  a_flag_set_branch_op_taken: assert property (
    accept && op_code == flow_pkg::flag_set_branch_op && status_flags[flag_sel] |->
      ##2 (op_done && pc_value == $past(pc_value, 2) + 24'h000001 + {{17{$past(branch_offset[6], 2)}},
      $past(branch_offset, 2)}))
    else $error("flag set branch target wrong");

  a_flag_clear_branch_op_untaken: assert property (
    accept && op_code == flow_pkg::flag_clear_branch_op && status_flags[flag_sel] |=>
      op_done && op_ready && pc_value == $past(pc_value) + 24'h000001)
    else $error("flag clear branch taken wrongly");

  a_equal_branch_op_cycles: assert property (
    accept && op_code == flow_pkg::equal_branch_op && status_flags[`FLAG_Z] |->
      ##1 (!op_ready && !op_done) ##1 (op_ready && op_done))
    else $error("equal branch timing wrong");

endmodule

// *** flow_exec_tb.sv ***
// Self-checking bench for the flow-control executor: APB register access and instruction port
`timescale 1ns/10ps
`include "flow_exec_cfg.svh"
module flow_exec_tb;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  op_valid = 1'b0;
  flow_pkg::op_type      op_code = flow_pkg::indirect_call_op;
  logic [7:0]            rd_value = 8'h00;
  logic [7:0]            rr_value = 8'h00;
  logic [7:0]            imm_value = 8'h00;
  logic [2:0]            bit_sel = 3'h0;
  logic [2:0]            flag_sel = 3'h0;
  logic [6:0]            branch_offset = 7'h00;
  logic [7:0]            io_value = 8'h00;
  logic [15:0]           pointer_value = 16'h0;
  logic                  next_two_word = 1'b0;
  logic                  op_ready;
  logic                  op_done;
  logic [23:0]           pc_value;
  logic                  stack_push;
  logic [7:0]            stack_data;
  int                    fails = 0;
  int                    n_compared = 0;
  int                    last_cyc;
  logic [23:0]           pc;
  logic [7:0]            pushed[$];

  flow_exec i_flow_exec (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
    .op_code(op_code), .rd_value(rd_value), .rr_value(rr_value), .imm_value(imm_value), .bit_sel(bit_sel),
    .flag_sel(flag_sel), .branch_offset(branch_offset), .io_value(io_value), .pointer_value(pointer_value),
    .next_two_word(next_two_word), .op_ready(op_ready), .op_done(op_done), .pc_value(pc_value),
    .stack_push(stack_push), .stack_data(stack_data)
  );

  always #50 pclk = ~pclk;

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fails++;
      conclude();
    end
  endtask

  task automatic wr_reg(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] d;
    logic        e;
    apb(1'b1, addr, data, d, e);
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, addr, 32'h0, d, e);
    chk(d, exp);
  endtask

  // Offers one instruction while idle, then counts cycles up to the done pulse
  task automatic run(input flow_pkg::op_type oc, input logic [7:0] rd, input logic [7:0] rr, input logic [7:0] io,
                     input logic [2:0] bs, input logic [6:0] k, input logic [15:0] ptr, input logic tw,
                     input logic [23:0] exp_pc, input int exp_cyc);
    @(posedge pclk);
    op_valid      <= 1'b1;
    op_code       <= oc;
    rd_value      <= rd;
    rr_value      <= (oc == flow_pkg::compare_immediate_op) ? ~rr : rr;
    imm_value     <= rr;
    bit_sel       <= bs;
    flag_sel      <= bs;
    branch_offset <= k;
    io_value      <= io;
    pointer_value <= ptr;
    next_two_word <= tw;
    @(posedge pclk);
    op_valid <= 1'b0;
    pushed.delete();
    last_cyc = 0;
    do begin
      #1;
      last_cyc++;
      if (stack_push === 1'b1)
        pushed.push_back(stack_data);
      if (op_done !== 1'b1)
        @(posedge pclk);
    end while (op_done !== 1'b1 && last_cyc < 20);
    if (last_cyc >= 20) begin
      fails++;
      conclude();
    end
    chk(pc_value, exp_pc);
    chk(last_cyc, exp_cyc);
    pc = exp_pc;
  endtask

  task automatic chk_push(input logic [23:0] ret);
    chk(pushed.size(), 3);
    if (pushed.size() == 3)
      chk({pushed[2], pushed[1], pushed[0]}, ret);
  endtask

  function automatic logic [7:0] cmp_flags(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    logic [7:0] f;
    r = a - b;
    f = 8'h00;
    f[`FLAG_C] = a < b;
    f[`FLAG_Z] = r == 8'h00;
    f[`FLAG_N] = r[7];
    f[`FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    f[`FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    return f;
  endfunction

  initial begin
    logic [31:0]      d;
    logic             e;
    logic             t;
    logic             tw;
    logic             setb;
    logic             isio;
    logic [7:0]       bv;
    logic [7:0]       rr;
    logic [7:0]       io;
    logic [6:0]       k;
    logic [7:0]       fl;
    int               adv;
    flow_pkg::op_type skops[5];
    logic [7:0]       ca[5];
    logic [7:0]       cb[5];
    skops = '{flow_pkg::compare_skip_equal_op, flow_pkg::reg_bit_clear_skip_op, flow_pkg::reg_bit_set_skip_op,
              flow_pkg::io_bit_clear_skip_op, flow_pkg::io_bit_set_skip_op};
    ca = '{8'h00, 8'h80, 8'h10, 8'h7F, 8'h08};
    cb = '{8'h01, 8'h01, 8'h10, 8'hFF, 8'h01};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(pc_value, 32'h0);
    chk(op_ready, 32'h1);
    // Ready high, no error, no done pulse and no push straight after reset
    chk({pready, pslverr, op_done, stack_push, stack_data}, 32'h800);
    rd_chk(`OFS_STATUS_FLAGS, {24'h0, `RST_STATUS_FLAGS});
    rd_chk(`OFS_EXT_PAGE, {24'h0, `RST_EXT_PAGE});
    rd_chk(`OFS_PC, {8'h0, `RST_PC});
    // Unmapped place answers with an error and reads zero
    apb(1'b0, 8'h10, 32'h0, d, e);
    chk(e, 32'h1);
    chk(d, 32'h0);
    wr_reg(`OFS_STATUS_FLAGS, 32'hD3);
    wr_reg(`OFS_EXT_PAGE, 32'h5A);
    wr_reg(`OFS_PC, 32'h000100);
    pc = 24'h000100;
    rd_chk(`OFS_PC, 32'h000100);
    // Plain indirect call must ignore the page register
    run(flow_pkg::indirect_call_op, 8'h0, 8'h0, 8'h0, 3'h0, 7'h0, 16'h1234, 1'b0, 24'h001234, 4);
    chk_push(24'h000101);
    run(flow_pkg::extended_indirect_call_op, 8'h0, 8'h0, 8'h0, 3'h0, 7'h0, 16'hBEEF, 1'b0, 24'h5ABEEF, 4);
    chk_push(24'h001235);
    rd_chk(`OFS_EXEC_STATE, 32'h40);
    for (int i = 0; i < 5; i++) begin
      for (int v = 0; v < 3; v++) begin
        t = (v > 0);
        tw = (v != 1);
        setb = (skops[i] == flow_pkg::reg_bit_set_skip_op) || (skops[i] == flow_pkg::io_bit_set_skip_op);
        isio = (skops[i] == flow_pkg::io_bit_clear_skip_op) || (skops[i] == flow_pkg::io_bit_set_skip_op);
        bv = (t ~^ setb) ? 8'h20 : 8'hDF;
        // The untested operand carries the opposite bit so a wrong source shows
        rr = isio ? ~bv : bv;
        io = isio ? bv : ~bv;
        if (i == 0) begin
          rr = t ? 8'h3C : 8'hC3;
          io = 8'h3C;
        end
        adv = t ? (tw ? 3 : 2) : 1;
        run(skops[i], 8'h3C, rr, io, 3'h5, 7'h0, 16'h0, tw, pc + adv[23:0], adv);
      end
    end
    rd_chk(`OFS_STATUS_FLAGS, 32'hD3);
    wr_reg(`OFS_STATUS_FLAGS, 32'hA5);
    for (int s = 0; s < 8; s++) begin
      k = s[0] ? 7'h7C : 7'h05;
      fl = 8'hA5;
      t = fl[s];
      run(flow_pkg::flag_set_branch_op, 8'h0, 8'h0, 8'h0, s[2:0], k, 16'h0, 1'b0,
          t ? pc + {{17{k[6]}}, k} + 24'h1 : pc + 24'h1, t ? 2 : 1);
      run(flow_pkg::flag_clear_branch_op, 8'h0, 8'h0, 8'h0, s[2:0], k, 16'h0, 1'b0,
          t ? pc + 24'h1 : pc + {{17{k[6]}}, k} + 24'h1, t ? 1 : 2);
    end
    // Selector points at a set carry flag, so only the zero flag may decide
    run(flow_pkg::equal_branch_op, 8'h0, 8'h0, 8'h0, 3'h0, 7'h7E, 16'h0, 1'b0, pc + 24'h1, 1);
    wr_reg(`OFS_STATUS_FLAGS, 32'hA7);
    run(flow_pkg::equal_branch_op, 8'h0, 8'h0, 8'h0, 3'h0, 7'h7E, 16'h0, 1'b0, pc - 24'h1, 2);
    rd_chk(`OFS_STATUS_FLAGS, 32'hA7);
    wr_reg(`OFS_STATUS_FLAGS, 32'hFF);
    for (int i = 0; i < 5; i++) begin
      run(flow_pkg::compare_immediate_op, ca[i], cb[i], 8'h0, 3'h0, 7'h0, 16'h0, 1'b0, pc + 24'h1, 1);
      fl = 8'hD0 | cmp_flags(ca[i], cb[i]);
      rd_chk(`OFS_STATUS_FLAGS, {24'h0, fl});
    end
    conclude();
  end
endmodule
